//--- sipd_regs.svh
/*
 Register offsets, reset values and timing counts for the step-interval
 and standstill power-down timer. Assumes inclusion by bare name.
*/
`ifndef SIPD_REGS_SVH
`define SIPD_REGS_SVH
`define SIPD_OFS_PD_DELAY    7'h13
`define SIPD_OFS_STEP_INT    7'h14
`define SIPD_PD_DELAY_RST    8'h0A
`define SIPD_PD_UNIT_LOG2    18
`define SIPD_STEP_INT_RST    20'h00000
`define SIPD_STEP_INT_MAX    20'hFFFFF
`define SIPD_AUTO_OFS_MIN    8'h02
`endif

//--- sipd_pkg.sv
/*
 Types shared by the timer block. Assumes nothing of its surroundings.
*/
`default_nettype none
package sipd_pkg;
   typedef enum logic [1:0] {
      SIPD_MOVING,
      SIPD_DELAY,
      SIPD_RAMP_DOWN
   } sipd_pd_state_t;
endpackage
`default_nettype wire

//--- sipd_hyst_cmp.sv
/*
 Threshold comparator with hysteresis against the step interval.
 Assumes step_interval and threshold come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sipd_hyst_cmp #(
   parameter int W = 20
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] step_interval,
   input  wire logic [W-1:0] threshold,
   input  wire logic         narrow_hyst,
   output logic              slow_q
);
   logic [W-1:0] hyst;
   logic [W-1:0] upper_cmp;

   // Hysteresis is 1/16 or 1/32 of the threshold
   assign hyst      = narrow_hyst ? (threshold >> 5) : (threshold >> 4); // RULE6
   // Second compare value: threshold*15/16-1 (or 31/32)
   assign upper_cmp = threshold - hyst - W'(1); // RULE7

   // Slow when interval reaches threshold; fast only at or below the lowered value
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_q <= 1'b1;
      end else if (step_interval >= threshold) begin
         slow_q <= 1'b1; // RULE7
      end else if (step_interval <= upper_cmp && threshold != '0) begin
         slow_q <= 1'b0; // RULE6
      end
   end
endmodule
`default_nettype wire

//--- sipd_timer.sv
// Function
// RULE1: 8-bit power-down delay register, resets ten
// RULE2: Delay equals setting times 2^18 clocks
// RULE3: Software keeps delay at least two
// RULE4: Measure clocks between microsteps, 20-bit read-only
// RULE5: Saturate all-ones on overflow or standstill
// RULE6: Threshold compare hysteresis 1/16 or 1/32
// RULE7: Second compare value threshold*15/16 minus one
// RULE8: Ramp steps give interval near 2^24/V
// RULE9: Per-microstep interval reported, never averaged
// RULE10: Current reduction starts after delay expires
// RULE11: Microstep restarts counter, aborts power-down delay
/*
 Step-interval measurement and standstill power-down delay timer with its
 register port, plus one hysteretic threshold compare of the interval.
 Assumes microstep strobe, standstill flag and the register port are
 synchronous to clk; thresholds come from elsewhere in the chip.
 Limitations worth knowing:
 - The delay setting is captured when standstill starts; a rewrite while
   the delay runs only counts from the next standstill.
 - Overflow needs 2^20 quiet clocks, far slower than standstill detection
   in practice; both end in the same all-ones interval value.
 - Read data is registered and holds until the next read strobe.
 - The hand-off level stays high until standstill ends or a microstep
   arrives; the hold-current ramp paces itself from there.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipd_regs.svh"
module sipd_timer
   import sipd_pkg::*;
#(
   parameter int IW       = 20,
   parameter int PD_UNIT  = 1 << `SIPD_PD_UNIT_LOG2
) (
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          microstep,
   input  wire logic          standstill,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [6:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   output logic      [31:0]   reg_rdata_q,
   input  wire logic [IW-1:0] vel_threshold,
   input  wire logic          narrow_hyst,
   output logic               below_threshold_q,
   output logic               auto_pwm_offset_ok_q,
   output logic               power_down_start_q
);
   // Saturation value and prescaler width; a short unit in simulation
   // shrinks the prescaler without touching the sequencer
   localparam logic [IW-1:0] INT_MAX = `SIPD_STEP_INT_MAX;
   localparam int            UW      = (PD_UNIT > 1) ? $clog2(PD_UNIT) : 1;

   // Register state, counters and their helpers
   logic [7:0]     power_down_delay_q;
   logic [IW-1:0]  step_interval_q;
   logic [IW-1:0]  int_cnt_q;
   logic           int_ovf_q;
   logic [UW-1:0]  unit_cnt_q;
   logic [7:0]     unit_left_q;
   sipd_pd_state_t pd_state_q;
   logic           unit_tick;
   logic           pd_abort;
   logic           slow;
   logic [31:0]    reg_rdata_d;

   // Delay setting, writable by software
   // Only the low byte is kept; upper write bits are dropped
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_down_delay_q <= `SIPD_PD_DELAY_RST; // RULE1
      end else if (reg_wr && reg_addr == `SIPD_OFS_PD_DELAY) begin
         power_down_delay_q <= reg_wdata[7:0]; // RULE1
      end
   end

   // Interval counter; a held overflow flag avoids wrapping to small values
   // Restart value is one so N clocks between strobes read as N
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_cnt_q <= '0;
         int_ovf_q <= 1'b0;
      end else if (microstep) begin
         int_cnt_q <= IW'(1); // RULE11
         int_ovf_q <= 1'b0;
      end else if (int_cnt_q == INT_MAX) begin
         int_ovf_q <= 1'b1; // RULE5
      end else begin
         int_cnt_q <= int_cnt_q + IW'(1); // RULE4
      end
   end

   // Latched interval: each microstep alone, no averaging
   // Standstill wins over a strobe so a stopped axis always reads slow
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         step_interval_q <= `SIPD_STEP_INT_RST; // RULE4
      end else if (standstill || (int_ovf_q && !microstep)) begin
         step_interval_q <= INT_MAX; // RULE5
      end else if (microstep) begin
         step_interval_q <= int_ovf_q ? INT_MAX : int_cnt_q; // RULE9 RULE8
      end
   end

   // Prescaler of PD_UNIT clocks, runs only while the delay is pending;
   // held at zero otherwise so every delay starts on a whole unit
   assign unit_tick = (unit_cnt_q == UW'(PD_UNIT - 1));
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         unit_cnt_q <= '0;
      end else if (pd_state_q != SIPD_DELAY || unit_tick) begin
         unit_cnt_q <= '0; // RULE2
      end else begin
         unit_cnt_q <= unit_cnt_q + UW'(1);
      end
   end

   // Any microstep or end of standstill ends a pending delay at once
   assign pd_abort = microstep || !standstill; // RULE11

   // Power-down sequencer: standstill starts delay, microstep aborts it
   // The setting is captured on entry so a rewrite cannot stretch a delay
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pd_state_q  <= SIPD_MOVING;
         unit_left_q <= '0;
      end else if (pd_abort) begin
         pd_state_q  <= SIPD_MOVING; // RULE11
         unit_left_q <= '0;
      end else begin
         case (pd_state_q)
            SIPD_MOVING: begin
               // Capture the setting; zero skips the delay entirely
               pd_state_q  <= (power_down_delay_q == '0) ? SIPD_RAMP_DOWN : SIPD_DELAY;
               unit_left_q <= power_down_delay_q; // RULE10
            end
            SIPD_DELAY: begin
               // One unit gone per prescaler wrap
               if (unit_tick) begin
                  unit_left_q <= unit_left_q - 8'(1); // RULE2
                  if (unit_left_q == 8'(1)) begin
                     pd_state_q <= SIPD_RAMP_DOWN; // RULE10
                  end
               end
            end
            default: begin
               pd_state_q <= SIPD_RAMP_DOWN;
            end
         endcase
      end
   end

   // Hand-off level to the hold-current ramp sequencer
   // Dropped in the same edge as an abort so no stale start leaks out
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_down_start_q <= 1'b0;
      end else begin
         power_down_start_q <= (pd_state_q == SIPD_RAMP_DOWN) && !pd_abort; // RULE10
      end
   end

   // Offset auto-tuning only possible with a long enough delay
   // Advisory only; software keeps the setting in range
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         auto_pwm_offset_ok_q <= 1'b1;
      end else begin
         auto_pwm_offset_ok_q <= (power_down_delay_q >= `SIPD_AUTO_OFS_MIN); // RULE3
      end
   end

   // Threshold compare on the latched interval, not the running count,
   // so the result only moves at microstep, standstill or counter overflow events, or when vel_threshold or narrow_hyst change
   sipd_hyst_cmp #(
      .W             (IW)
   ) u_cmp (
      .clk           (clk),
      .rst_b         (rst_b),
      .step_interval (step_interval_q),
      .threshold     (vel_threshold),
      .narrow_hyst   (narrow_hyst),
      .slow_q        (slow)
   );

   // Registered copy so the output comes from a flop here
   // Costs one more cycle of latency, harmless at step rates
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         below_threshold_q <= 1'b1;
      end else begin
         below_threshold_q <= slow;
      end
   end

   // Read mux; unmapped offsets read zero, unused upper bits read zero
   always_comb begin
      reg_rdata_d = reg_rdata_q;
      if (reg_rd) begin
         if (reg_addr == `SIPD_OFS_PD_DELAY) begin
            reg_rdata_d = {24'h000000, power_down_delay_q}; // RULE1
         end else if (reg_addr == `SIPD_OFS_STEP_INT) begin
            reg_rdata_d = 32'(step_interval_q); // RULE4
         end else begin
            reg_rdata_d = 32'h00000000;
         end
      end
   end

   // Read data register; holds between reads so a slow reader still sees it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= '0;
      end else begin
         reg_rdata_q <= reg_rdata_d;
      end
   end
endmodule
`default_nettype wire

//--- sipd_timer_asserts.sv
/*
 Port checker for the step-interval and power-down timer.
 Assumes one clock and an async active-low reset on the bound instance.
*/
`timescale 1ns/1ps
`default_nettype none
module sipd_timer_asserts (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        microstep,
   input wire logic        standstill,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [6:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata_q,
   input wire logic        below_threshold_q,
   input wire logic        auto_pwm_offset_ok_q,
   input wire logic        power_down_start_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Read data width and holding
   pd_read_a: assert property (reg_rd && reg_addr == 7'h13 |=> reg_rdata_q[31:8] == 24'h0)
      else $error("delay read shows upper bits");
   int_read_a: assert property (reg_rd && reg_addr == 7'h14 |=> reg_rdata_q[31:20] == 12'h0)
      else $error("interval read shows upper bits");
   rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
      else $error("read data moved without a read");
   // Offset tuning flag follows the delay setting
   ok_set_a: assert property (reg_wr && reg_addr == 7'h13 && reg_wdata[7:0] >= 8'h02
      |-> ##[1:2] auto_pwm_offset_ok_q) else $error("tuning flag not set");
   ok_clr_a: assert property (reg_wr && reg_addr == 7'h13 && reg_wdata[7:0] < 8'h02
      |-> ##[1:2] !auto_pwm_offset_ok_q) else $error("tuning flag not cleared");
   // Power-down hand-off only during undisturbed standstill
   pd_abort_a: assert property (microstep |=> !power_down_start_q)
      else $error("power-down start survived a microstep");
   pd_stst_a: assert property (!standstill |=> !power_down_start_q)
      else $error("power-down start without standstill");
   // Standstill saturates the interval, which is then on the slow side
   sat_slow_a: assert property ((standstill && !microstep)[*4] |-> below_threshold_q)
      else $error("saturated interval not slow");
endmodule
bind sipd_timer sipd_timer_asserts i_chk (.clk(clk), .rst_b(rst_b), .microstep(microstep),
   .standstill(standstill), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .below_threshold_q(below_threshold_q),
   .auto_pwm_offset_ok_q(auto_pwm_offset_ok_q), .power_down_start_q(power_down_start_q));
`default_nettype wire

//--- tb_step_interval_and_powerdown_timer.sv
/*
 Self-checking bench for the step-interval and power-down timer.
 Assumes design files compiled first; delay unit shortened to 16 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_step_interval_and_powerdown_timer;
   localparam int UNIT = 16;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        microstep = 1'b0;
   logic        standstill = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [6:0]  reg_addr = 7'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [19:0] vel_threshold = 20'h00100;
   logic        narrow_hyst = 1'b0;
   logic [31:0] rdata;
   logic        below, ok, pd_start;
   int          fails = 0;
   int          cmp_count = 0;
   sipd_timer #(.PD_UNIT(UNIT)) i_dut (.clk(clk), .rst_b(rst_b), .microstep(microstep),
      .standstill(standstill), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .vel_threshold(vel_threshold),
      .narrow_hyst(narrow_hyst), .below_threshold_q(below), .auto_pwm_offset_ok_q(ok),
      .power_down_start_q(pd_start));
   // 50 ns clock
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   // Inputs move 1 ns after the edge, away from sampling
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Extra idle cycle so strobes never toggle twice in one step
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(2);
   endtask
   task automatic rd(input logic [6:0] a, output logic [31:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      cyc(1);
      d = rdata;
   endtask
   task automatic pulse;
      microstep = 1'b1;
      cyc(1);
      microstep = 1'b0;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_reset;
      logic [31:0] d;
      rd(7'h13, d);
      chk("delay", 32'h0000000A, d);
      rd(7'h14, d);
      chk("interval", 32'h0, d);
      chk("tune ok", 32'h1, ok);
      $display("test reset done");
   endtask
   task automatic t_interval;
      logic [31:0] d;
      pulse;
      cyc(39);
      pulse;
      cyc(2);
      rd(7'h14, d);
      chk("gap 40", 32'h00000028, d);
      cyc(25);
      pulse;
      cyc(2);
      rd(7'h14, d);
      chk("gap 30", 32'h0000001E, d);
      cyc(59);
      pulse;
      cyc(2);
      rd(7'h14, d);
      chk("gap 64", 32'h00000040, d);
      chk("v 2^18", 32'h1, (d >= 32'h3F && d <= 32'h40));
      standstill = 1'b1;
      cyc(2);
      rd(7'h14, d);
      chk("standstill", 32'h000FFFFF, d);
      standstill = 1'b0;
      $display("test interval done");
   endtask
   task automatic t_pwrdn;
      logic [31:0] d;
      int          n;
      wr(7'h13, 32'h00000103);
      rd(7'h13, d);
      chk("delay 3", 32'h00000003, d);
      wr(7'h14, 32'h00000005);
      rd(7'h14, d);
      chk("ro interval", 32'h000FFFFF, d);
      standstill = 1'b1;
      for (n = 0; n < 200 && pd_start !== 1'b1; n++) cyc(1);
      if (n == 200) begin
         fails++;
         report_and_stop;
      end
      chk("pd time", 32'h1, (n >= 3 * UNIT && n <= 3 * UNIT + 4));
      pulse;
      cyc(1);
      chk("pd abort", 32'h0, pd_start);
      standstill = 1'b0;
      wr(7'h13, 32'h00000000);
      standstill = 1'b1;
      cyc(3);
      chk("pd zero", 32'h1, pd_start);
      standstill = 1'b0;
      cyc(1);
      chk("pd motion", 32'h0, pd_start);
      wr(7'h13, 32'h00000001);
      chk("tune off", 32'h0, ok);
      wr(7'h13, 32'h00000002);
      chk("tune on", 32'h1, ok);
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      cyc(1);
      rd(7'h13, d);
      chk("delay rst", 32'h0000000A, d);
      chk("tune rst", 32'h1, ok);
      $display("test power-down done");
   endtask
   // Gaps around 256, 256*15/16-1 and 256*31/32-1
   task automatic t_hyst;
      int   g[7] = '{256, 240, 239, 255, 256, 248, 247};
      logic e[7] = '{1, 1, 0, 0, 1, 1, 0};
      pulse;
      cyc(4);
      foreach (g[i]) begin
         narrow_hyst = (i > 4);
         cyc(g[i] - 5);
         pulse;
         cyc(4);
         chk("slow", e[i], below);
      end
      $display("test hysteresis done");
   endtask
   initial begin
      cyc(16);
      rst_b = 1'b1;
      cyc(1);
      t_reset;
      t_interval;
      t_pwrdn;
      t_hyst;
      report_and_stop;
   end
endmodule
`default_nettype wire
